// ===== port_mode_pkg.sv
// Constants, register offsets and reset values for the expansion port mode logic.
package port_mode_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	// Register offsets in the port register window.
	localparam logic [7:0] OFF_PORT_A_DATA_IN = 8'h00;
	localparam logic [7:0] OFF_PORT_B_DATA_IN = 8'h01;
	localparam logic [7:0] OFF_PORT_B_ADDR_OUT_SEL = 8'h03;
	localparam logic [7:0] OFF_PORT_A_DATA_OUT = 8'h04;
	localparam logic [7:0] OFF_PORT_B_DATA_OUT = 8'h05;
	localparam logic [7:0] OFF_PORT_A_DIR = 8'h06;
	localparam logic [7:0] OFF_PORT_B_DIR = 8'h07;
	localparam logic [7:0] OFF_PORT_A_OE = 8'h0c;
	localparam logic [7:0] OFF_PORT_B_OE = 8'h0d;
	localparam logic [7:0] OFF_PORT_B_HIGH_SEL = 8'h0e;
	localparam logic [7:0] OFF_PORT_C_ISP = 8'h0f;
	localparam logic [7:0] OFF_MEMORY_MODE = 8'h10;
	// Field positions.
	localparam int REPEATER_ENABLE_BIT = 7;
	localparam int ISP_STATUS_EN_BIT = 0;
	localparam int ISP_ERROR_EN_BIT = 1;
	// Reset values.
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] RST_ONES = 8'hff;
	// Wishbone window address width, in byte addresses of 32-bit words.
	localparam int WB_ADR_W = 8;
endpackage

// ===== port_link_if.sv
// Interface joining the port mode logic to the external pins and processor bus.
`timescale 1ns/10ps
`default_nettype none
interface port_link_if;
	import port_mode_pkg::*;
	// Processor bus as seen by the port logic.
	logic [ADDR_W-1:0] cpu_addr;
	logic [DATA_W-1:0] cpu_wdata;
	logic [DATA_W-1:0] cpu_rdata;
	logic cpu_rd_n;
	logic cpu_wr_n;
	logic program_fetch_strobe_n;
	logic periph_range_select_0;
	logic periph_range_select_1;
	// Logic array drive for the pins.
	logic [DATA_W-1:0] output_macrocell_a;
	logic [DATA_W-1:0] output_macrocell_a_used;
	logic [DATA_W-1:0] output_macrocell_b;
	logic [DATA_W-1:0] output_macrocell_b_used;
	// Pins: input, output, enable.
	logic [DATA_W-1:0] pa_in;
	logic [DATA_W-1:0] pa_out;
	logic [DATA_W-1:0] pa_oe;
	logic [DATA_W-1:0] pb_in;
	logic [DATA_W-1:0] pb_out;
	logic [DATA_W-1:0] pb_oe;
	logic isp_status_out;
	logic isp_error_out;
	logic isp_status_oe;
	logic isp_error_oe;
	modport device (input cpu_addr, cpu_wdata, cpu_rd_n, cpu_wr_n, program_fetch_strobe_n,
		periph_range_select_0, periph_range_select_1, output_macrocell_a,
		output_macrocell_a_used, output_macrocell_b, output_macrocell_b_used, pa_in, pb_in,
		output cpu_rdata, pa_out, pa_oe, pb_out, pb_oe, isp_status_out, isp_error_out,
		isp_status_oe, isp_error_oe);
	modport host (output cpu_addr, cpu_wdata, cpu_rd_n, cpu_wr_n, program_fetch_strobe_n,
		periph_range_select_0, periph_range_select_1, output_macrocell_a,
		output_macrocell_a_used, output_macrocell_b, output_macrocell_b_used, pa_in, pb_in,
		input cpu_rdata, pa_out, pa_oe, pb_out, pb_oe, isp_status_out, isp_error_out,
		isp_status_oe, isp_error_oe);
endinterface
`default_nettype wire

// ===== pin_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	// The first stage feeds only the second stage.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== port_mode_device.sv
// Device end: port registers, pin mode selection and peripheral repeater.
//
// Overview of operation
// - Direction bit 1 drives pin, 0 inputs.
// - Data-in reads pins; data-out sets driven level.
// - Direction writable anytime; mixed pins per port.
// - Macrocell-driven pin ignores direction bit.
// - Firmware keeps control bit 0 for I/O.
// - Firmware sets control and direction for address.
// - Control bit 1 drives address; resets zero.
// - Port B bit n carries A[n] or A[n+8].
// - Repeater buffers data bits D0-D7 only.
// - Read strobe pins-to-bus, write strobe bus-to-pins.
// - Repeater acts only inside OR of selects.
// - Firmware sets memory-mode bit 7; resets zero.
// - Repeater takes all eight port A pins.
// - Selects qualified by fetch strobe high.
// - Port C bits 3,4 optionally carry ISP status; here only driven low.
// - Enable from product term, direction, or repeater.
// - Read-only enable register shows final enables.
`timescale 1ns/10ps
`default_nettype none
module port_mode_device
	import port_mode_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	port_link_if.device link
);
	logic [DATA_W-1:0] pa_dout_q, pb_dout_q, pa_dir_q, pb_dir_q;
	logic [DATA_W-1:0] pb_addr_sel_q, pb_high_sel_q, isp_q, mem_mode_q;
	logic [DATA_W-1:0] pa_in_s, pb_in_s;
	logic [DATA_W-1:0] pa_oe_d, pb_oe_d, pa_out_d, pb_out_d, cpu_rdata_d;
	logic [DATA_W-1:0] pa_out_q, pa_oe_q, pb_out_q, pb_oe_q, cpu_rdata_q;
	logic [DATA_W-1:0] pa_oe_rd_q, pb_oe_rd_q;
	logic [2:0] bus_s;
	logic rep_en, in_range, rep_rd, rep_wr;
	logic wb_req, wb_wr;
	logic [7:0] reg_idx;
	logic [DATA_W-1:0] rdata_mux;

	// Pins come from outside the clock domain and are synchronised first.
	pin_sync #(.W(DATA_W)) sync_pa (.clk(clk), .rst_n(rst_n), .d(link.pa_in), .q(pa_in_s));
	pin_sync #(.W(DATA_W)) sync_pb (.clk(clk), .rst_n(rst_n), .d(link.pb_in), .q(pb_in_s));
	pin_sync #(.W(3)) sync_bus (.clk(clk), .rst_n(rst_n),
		.d({link.cpu_rd_n, link.cpu_wr_n, link.program_fetch_strobe_n}), .q(bus_s));

	// A word index is the byte address divided by four.
	assign reg_idx = {2'b00, wb_adr_i[WB_ADR_W-1:2]};
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// A write lands on the edge at which the master samples ack high, not when it is taken.
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

	// Function deciding whether a write hits a given offset.
	function automatic logic hit(input logic [7:0] idx, input logic [7:0] off);
		hit = (idx == off);
	endfunction

	// Writable configuration registers, written only on the acknowledged edge.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pa_dout_q <= RST_REG;
			pb_dout_q <= RST_REG;
			pa_dir_q <= RST_REG;
			pb_dir_q <= RST_REG;
			pb_addr_sel_q <= RST_REG;
			pb_high_sel_q <= RST_REG;
			isp_q <= RST_REG;
			mem_mode_q <= RST_REG;
		end else if (wb_wr) begin
			if (hit(reg_idx, OFF_PORT_A_DATA_OUT)) pa_dout_q <= wb_dat_i[7:0];
			if (hit(reg_idx, OFF_PORT_B_DATA_OUT)) pb_dout_q <= wb_dat_i[7:0];
			if (hit(reg_idx, OFF_PORT_A_DIR)) pa_dir_q <= wb_dat_i[7:0];
			if (hit(reg_idx, OFF_PORT_B_DIR)) pb_dir_q <= wb_dat_i[7:0];
			if (hit(reg_idx, OFF_PORT_B_ADDR_OUT_SEL)) pb_addr_sel_q <= wb_dat_i[7:0];
			if (hit(reg_idx, OFF_PORT_B_HIGH_SEL)) pb_high_sel_q <= wb_dat_i[7:0];
			if (hit(reg_idx, OFF_PORT_C_ISP)) isp_q <= wb_dat_i[7:0];
			if (hit(reg_idx, OFF_MEMORY_MODE)) mem_mode_q <= wb_dat_i[7:0];
		end
	end

	// Repeater qualification; the fetch strobe is also checked here so code cycles never leak.
	assign rep_en = mem_mode_q[REPEATER_ENABLE_BIT];
	assign in_range = (link.periph_range_select_0 || link.periph_range_select_1) && bus_s[0];
	assign rep_rd = rep_en && in_range && !bus_s[2];
	assign rep_wr = rep_en && in_range && !bus_s[1] && bus_s[2];

	// Pin drive and enable selection; repeater outranks everything on port A.
	always_comb begin
		for (int i = 0; i < DATA_W; i++) begin
			if (rep_en) begin
				pa_oe_d[i] = rep_wr;
				pa_out_d[i] = link.cpu_wdata[i];
			end else if (link.output_macrocell_a_used[i]) begin
				pa_oe_d[i] = 1'b1;
				pa_out_d[i] = link.output_macrocell_a[i];
			end else begin
				pa_oe_d[i] = pa_dir_q[i];
				pa_out_d[i] = pa_dout_q[i];
			end
			if (link.output_macrocell_b_used[i]) begin
				pb_oe_d[i] = 1'b1;
				pb_out_d[i] = link.output_macrocell_b[i];
			end else if (pb_addr_sel_q[i]) begin
				// Firmware is expected to set direction too; enable still follows it.
				pb_oe_d[i] = pb_dir_q[i];
				pb_out_d[i] = pb_high_sel_q[i] ? link.cpu_addr[i+8] : link.cpu_addr[i];
			end else begin
				pb_oe_d[i] = pb_dir_q[i];
				pb_out_d[i] = pb_dout_q[i];
			end
		end
		cpu_rdata_d = rep_rd ? pa_in_s : RST_REG;
	end

	// Pin outputs are registered so every output except the tied-low ISP pins comes from a flip-flop.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pa_out_q <= RST_REG;
			pa_oe_q <= RST_REG;
			pb_out_q <= RST_REG;
			pb_oe_q <= RST_REG;
			cpu_rdata_q <= RST_REG;
			pa_oe_rd_q <= RST_REG;
			pb_oe_rd_q <= RST_REG;
		end else begin
			pa_out_q <= pa_out_d;
			pa_oe_q <= pa_oe_d;
			pb_out_q <= pb_out_d;
			pb_oe_q <= pb_oe_d;
			cpu_rdata_q <= cpu_rdata_d;
			pa_oe_rd_q <= pa_oe_d;
			pb_oe_rd_q <= pb_oe_d;
		end
	end

	assign link.pa_out = pa_out_q;
	assign link.pa_oe = pa_oe_q;
	assign link.pb_out = pb_out_q;
	assign link.pb_oe = pb_oe_q;
	assign link.cpu_rdata = cpu_rdata_q;
	assign link.isp_status_out = 1'b0;
	assign link.isp_error_out = 1'b0;

	// Optional ISP pins are enabled from the port C control bits.
	logic isp_st_oe_q, isp_er_oe_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			isp_st_oe_q <= 1'b0;
			isp_er_oe_q <= 1'b0;
		end else begin
			isp_st_oe_q <= isp_q[ISP_STATUS_EN_BIT];
			isp_er_oe_q <= isp_q[ISP_ERROR_EN_BIT];
		end
	end
	assign link.isp_status_oe = isp_st_oe_q;
	assign link.isp_error_oe = isp_er_oe_q;

	// Read multiplexer; unmapped offsets read as zero.
	always_comb begin
		case (reg_idx)
			OFF_PORT_A_DATA_IN: rdata_mux = pa_in_s;
			OFF_PORT_B_DATA_IN: rdata_mux = pb_in_s;
			OFF_PORT_B_ADDR_OUT_SEL: rdata_mux = pb_addr_sel_q;
			OFF_PORT_A_DATA_OUT: rdata_mux = pa_dout_q;
			OFF_PORT_B_DATA_OUT: rdata_mux = pb_dout_q;
			OFF_PORT_A_DIR: rdata_mux = pa_dir_q;
			OFF_PORT_B_DIR: rdata_mux = pb_dir_q;
			OFF_PORT_A_OE: rdata_mux = pa_oe_rd_q;
			OFF_PORT_B_OE: rdata_mux = pb_oe_rd_q;
			OFF_PORT_B_HIGH_SEL: rdata_mux = pb_high_sel_q;
			OFF_PORT_C_ISP: rdata_mux = isp_q;
			OFF_MEMORY_MODE: rdata_mux = mem_mode_q;
			default: rdata_mux = RST_REG;
		endcase
	end

	// One acknowledge per request, registered one cycle after it and dropped the cycle after.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? {24'h00_0000, rdata_mux} : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// ===== port_mode_host.sv
// Host end: drives the processor bus, selects and macrocells, and models pin sources.
`timescale 1ns/10ps
`default_nettype none
module port_mode_host
	import port_mode_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic data_cycle,
	input wire logic sel0,
	input wire logic sel1,
	input wire logic [DATA_W-1:0] mc_a,
	input wire logic [DATA_W-1:0] mc_a_used,
	input wire logic [DATA_W-1:0] mc_b,
	input wire logic [DATA_W-1:0] mc_b_used,
	input wire logic [DATA_W-1:0] pa_drive,
	input wire logic [DATA_W-1:0] pb_drive,
	output logic [DATA_W-1:0] rdata,
	output logic [DATA_W-1:0] pa_seen,
	output logic [DATA_W-1:0] pb_seen,
	port_link_if.host link
);
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic rd_n_q, wr_n_q, fetch_n_q, sel0_q, sel1_q;
	logic [DATA_W-1:0] mc_a_q, mc_a_used_q, mc_b_q, mc_b_used_q, pa_q, pb_q;

	// Bus and select drive; selects only pass on data cycles so code fetches never open the repeater.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_q <= 16'h0000;
			wdata_q <= RST_REG;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			fetch_n_q <= 1'b1;
			sel0_q <= 1'b0;
			sel1_q <= 1'b0;
			mc_a_q <= RST_REG;
			mc_a_used_q <= RST_REG;
			mc_b_q <= RST_REG;
			mc_b_used_q <= RST_REG;
			pa_q <= RST_REG;
			pb_q <= RST_REG;
		end else begin
			addr_q <= addr;
			wdata_q <= wdata;
			rd_n_q <= !rd_req;
			wr_n_q <= !(wr_req && !rd_req);
			fetch_n_q <= data_cycle;
			sel0_q <= sel0 && data_cycle;
			sel1_q <= sel1 && data_cycle;
			mc_a_q <= mc_a;
			mc_a_used_q <= mc_a_used;
			mc_b_q <= mc_b;
			mc_b_used_q <= mc_b_used;
			pa_q <= pa_drive;
			pb_q <= pb_drive;
		end
	end

	// Resolved pin levels: the device drive wins where enabled, else the outside source.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= RST_REG;
			pa_seen <= RST_REG;
			pb_seen <= RST_REG;
		end else begin
			rdata <= link.cpu_rdata;
			pa_seen <= (link.pa_oe & link.pa_out) | (~link.pa_oe & pa_q);
			pb_seen <= (link.pb_oe & link.pb_out) | (~link.pb_oe & pb_q);
		end
	end

	assign link.cpu_addr = addr_q;
	assign link.cpu_wdata = wdata_q;
	assign link.cpu_rd_n = rd_n_q;
	assign link.cpu_wr_n = wr_n_q;
	assign link.program_fetch_strobe_n = fetch_n_q;
	assign link.periph_range_select_0 = sel0_q;
	assign link.periph_range_select_1 = sel1_q;
	assign link.output_macrocell_a = mc_a_q;
	assign link.output_macrocell_a_used = mc_a_used_q;
	assign link.output_macrocell_b = mc_b_q;
	assign link.output_macrocell_b_used = mc_b_used_q;
	// Outside world sees its own source where the device does not drive.
	assign link.pa_in = (pa_oe_mix(link.pa_oe, link.pa_out, pa_q));
	assign link.pb_in = (pa_oe_mix(link.pb_oe, link.pb_out, pb_q));

	// Wire resolution of one port, used for both ports.
	function automatic logic [DATA_W-1:0] pa_oe_mix(input logic [DATA_W-1:0] oe,
		input logic [DATA_W-1:0] dout, input logic [DATA_W-1:0] ext);
		pa_oe_mix = (oe & dout) | (~oe & ext);
	endfunction
endmodule
`default_nettype wire

// ===== port_mode_assertions.sv
// Concurrent checks on the link between the port mode device and host ends.
`timescale 1ns/10ps
`default_nettype none
module port_mode_assertions
	import port_mode_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cpu_rd_n,
	input wire logic cpu_wr_n,
	input wire logic periph_range_select_0,
	input wire logic periph_range_select_1,
	input wire logic [DATA_W-1:0] pa_in,
	input wire logic [DATA_W-1:0] pa_oe,
	input wire logic [DATA_W-1:0] pb_oe,
	input wire logic [DATA_W-1:0] cpu_rdata,
	input wire logic isp_status_out,
	input wire logic isp_error_out
);
	logic [4:0] sel_h_q;
	logic [DATA_W-1:0] pin_h_q [5];
	wire logic rdata_live = (cpu_rdata != '0);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Short histories, because strobes and pins reach the read data through synchronisers.
	always_ff @(posedge clk) begin
		sel_h_q <= {sel_h_q[3:0], periph_range_select_0 | periph_range_select_1};
		pin_h_q <= '{pa_in, pin_h_q[0], pin_h_q[1], pin_h_q[2], pin_h_q[3]};
	end
	sequence s_read_idle;
		cpu_rd_n [*6];
	endsequence
	sequence s_steady_read;
		(!cpu_rd_n && cpu_wr_n && (periph_range_select_0 || periph_range_select_1)
			&& $stable(pa_in)) [*6];
	endsequence
	AST_ISP_STATUS_LOW: assert property (isp_status_out == 1'b0)
		else $error("status pin not low");
	AST_ISP_ERROR_LOW: assert property (isp_error_out == 1'b0)
		else $error("error pin not low");
	AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n |=> (pa_oe == '0 && pb_oe == '0 && cpu_rdata == '0))
		else $error("outputs active after reset edge");
	AST_RDATA_IDLE_ZERO: assert property (s_read_idle |-> cpu_rdata == '0)
		else $error("read data without read strobe");
	AST_RDATA_NEEDS_SELECT: assert property (rdata_live |-> sel_h_q != '0)
		else $error("read data without range select");
	AST_RDATA_FROM_PINS: assert property (rdata_live |-> (cpu_rdata == pin_h_q[0] || cpu_rdata == pin_h_q[1] || cpu_rdata == pin_h_q[2] || cpu_rdata == pin_h_q[3] || cpu_rdata == pin_h_q[4]))
		else $error("read data not from port pins");
	AST_READ_RELEASES_PINS: assert property (rdata_live |-> pa_oe == '0)
		else $error("port driven during read");
	AST_STEADY_READ_MATCH: assert property (s_steady_read |-> (cpu_rdata == pa_in || cpu_rdata == '0))
		else $error("read data differs from steady pins");
endmodule
`default_nettype wire

// ===== expansion_port_mode_logic_tb_top.sv
// Self-checking testbench joining the device and host ends of the port mode logic.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module expansion_port_mode_logic_tb_top
	import port_mode_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0] adr = 8'h00, q;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_w = 32'h0000_0000, dat_r, v, seed = 32'h6279_abcc;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0, mc_a = '0, mc_a_used = '0, mc_b = '0, mc_b_used = '0;
	logic [DATA_W-1:0] pa_drive = '0, pb_drive = '0, rdata, pa_seen, pb_seen;
	// Fetch strobe starts high so selects mark data cycles; one scenario fakes a fetch.
	logic rd_req = 1'b0, wr_req = 1'b0, data_cycle = 1'b1, sel0 = 1'b0, sel1 = 1'b0;
	int n_mismatch = 0, samples_checked = 0, cycles = 0;
	always #25 clk = ~clk;
	port_link_if i_port_link_if ();
	port_mode_device i_port_mode_device (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
		.wb_dat_o(dat_r), .wb_ack_o(ack), .link(i_port_link_if));
	port_mode_host i_port_mode_host (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.rd_req(rd_req), .wr_req(wr_req), .data_cycle(data_cycle), .sel0(sel0), .sel1(sel1),
		.mc_a(mc_a), .mc_a_used(mc_a_used), .mc_b(mc_b), .mc_b_used(mc_b_used),
		.pa_drive(pa_drive), .pb_drive(pb_drive), .rdata(rdata), .pa_seen(pa_seen),
		.pb_seen(pb_seen), .link(i_port_link_if));
	port_mode_assertions i_port_mode_assertions (.clk(clk), .rst_n(rst_n),
		.cpu_rd_n(i_port_link_if.cpu_rd_n), .cpu_wr_n(i_port_link_if.cpu_wr_n),
		.periph_range_select_0(i_port_link_if.periph_range_select_0),
		.periph_range_select_1(i_port_link_if.periph_range_select_1),
		.pa_in(i_port_link_if.pa_in), .pa_oe(i_port_link_if.pa_oe), .pb_oe(i_port_link_if.pb_oe),
		.cpu_rdata(i_port_link_if.cpu_rdata), .isp_status_out(i_port_link_if.isp_status_out),
		.isp_error_out(i_port_link_if.isp_error_out));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Level on a pin: own driver where enabled, else the outside source.
	function automatic logic [7:0] pin(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] e);
		return (oe & o) | (~oe & e);
	endfunction
	task automatic print_verdict();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Classic single Wishbone cycle; the request is held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] off, input logic [3:0] s, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= {off[5:0], 2'b00};
		dat_w <= {24'h00_0000, d};
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = dat_r[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic chk_reg(input logic [7:0] off, input logic [7:0] exp);
		wb(1'b0, off, 4'hf, 8'h00);
		`CHK(q, exp)
	endtask
	// A hang is cut short here and counted as a mismatch.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		chk_reg(OFF_PORT_B_ADDR_OUT_SEL, RST_REG);
		chk_reg(OFF_MEMORY_MODE, RST_REG);
		chk_reg(OFF_PORT_A_OE, RST_REG);
		wb(1'b1, 8'h3f, 4'hf, 8'h5a);
		chk_reg(8'h3f, 8'h00);
		wb(1'b1, OFF_PORT_A_DATA_OUT, 4'hf, 8'h11);
		wb(1'b1, OFF_PORT_A_DATA_OUT, 4'he, 8'hff);
		chk_reg(OFF_PORT_A_DATA_OUT, 8'h11);
		// Processor I/O mode with random directions, first with a fixed corner.
		for (int k = 0; k < 12; k++) begin
			seed = xs(seed);
			v = (k == 0) ? 32'hff00_00ff : seed;
			wb(1'b1, OFF_PORT_A_DIR, 4'hf, v[7:0]);
			wb(1'b1, OFF_PORT_A_DATA_OUT, 4'hf, v[15:8]);
			wb(1'b1, OFF_PORT_B_DIR, 4'hf, v[23:16]);
			wb(1'b1, OFF_PORT_B_DATA_OUT, 4'hf, v[31:24]);
			seed = xs(seed);
			pa_drive <= seed[7:0];
			pb_drive <= seed[15:8];
			repeat (8) @(posedge clk);
			`CHK(pa_seen, pin(v[7:0], v[15:8], seed[7:0]))
			`CHK(pb_seen, pin(v[23:16], v[31:24], seed[15:8]))
			chk_reg(OFF_PORT_A_DATA_IN, pin(v[7:0], v[15:8], seed[7:0]));
			chk_reg(OFF_PORT_B_DATA_IN, pin(v[23:16], v[31:24], seed[15:8]));
			chk_reg(OFF_PORT_B_OE, v[23:16]);
		end
		// Macrocell pins ignore the direction bits.
		seed = xs(seed);
		mc_a <= seed[7:0];
		mc_a_used <= seed[15:8];
		mc_b <= seed[23:16];
		mc_b_used <= seed[31:24];
		repeat (8) @(posedge clk);
		`CHK(pa_seen & seed[15:8], seed[7:0] & seed[15:8])
		`CHK(pb_seen & seed[31:24], seed[23:16] & seed[31:24])
		mc_a_used <= '0;
		mc_b_used <= '0;
		// Latched address on port B, low or high byte per bit.
		seed = xs(seed);
		v = seed;
		wb(1'b1, OFF_PORT_B_DIR, 4'hf, 8'hff);
		wb(1'b1, OFF_PORT_B_HIGH_SEL, 4'hf, v[7:0]);
		wb(1'b1, OFF_PORT_B_ADDR_OUT_SEL, 4'hf, v[15:8]);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			addr <= seed[15:0];
			repeat (8) @(posedge clk);
			`CHK(pb_seen & v[15:8], pin(v[7:0], seed[15:8], seed[7:0]) & v[15:8])
		end
		chk_reg(OFF_PORT_B_ADDR_OUT_SEL, v[15:8]);
		chk_reg(OFF_PORT_B_HIGH_SEL, v[7:0]);
		wb(1'b1, OFF_PORT_B_ADDR_OUT_SEL, 4'hf, 8'h00);
		wb(1'b1, OFF_PORT_C_ISP, 4'hf, 8'h03);
		repeat (4) @(posedge clk);
		`CHK({i_port_link_if.isp_status_oe, i_port_link_if.isp_error_oe}, 2'b11)
		chk_reg(OFF_PORT_C_ISP, 8'h03);
		// Repeater: write in range, write out of range, read via second select, code fetch.
		wb(1'b1, OFF_MEMORY_MODE, 4'hf, 8'h80);
		chk_reg(OFF_MEMORY_MODE, 8'h80);
		wb(1'b1, OFF_PORT_A_DIR, 4'hf, 8'h0f);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			wdata <= seed[7:0];
			pa_drive <= seed[15:8];
			data_cycle <= (k != 3);
			sel0 <= (k == 0 || k == 3);
			sel1 <= (k == 2);
			wr_req <= (k < 2);
			rd_req <= (k >= 2);
			repeat (8) @(posedge clk);
			chk_reg(OFF_PORT_A_OE, (k == 0) ? 8'hff : 8'h00);
			`CHK(pa_seen, (k == 0) ? seed[7:0] : seed[15:8])
			`CHK(rdata, (k == 2) ? seed[15:8] : 8'h00)
			wr_req <= 1'b0;
			rd_req <= 1'b0;
			repeat (4) @(posedge clk);
		end
		data_cycle <= 1'b1;
		sel0 <= 1'b0;
		sel1 <= 1'b0;
		wb(1'b1, OFF_MEMORY_MODE, 4'hf, 8'h00);
		repeat (6) @(posedge clk);
		chk_reg(OFF_PORT_A_OE, 8'h0f);
		// A second reset in mid-run must bring the registers back to their defaults.
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		chk_reg(OFF_PORT_A_DIR, RST_REG);
		chk_reg(OFF_PORT_C_ISP, RST_REG);
		print_verdict();
	end
endmodule
`default_nettype wire
